// file: design/swcwc_pkg.sv
// Notes on behaviour
// - watchdog bit 6 set asks for watchdog off in stop mode
// - watchdog bit 5 picks time-out (0) or window (1) watchdog
// - watchdog bit 4 set starts watchdog with long open window after bus wake
// - reserved bits always read back as zero
// - mode bits 1:0 give off, wake, receive-only, normal; bit 2 adds selective wake
// - selective wake bit changes only by host write or reload, never by mode events
// - normal mode at sleep entry without system error becomes wake capable
// - receive-only becomes wake capable on sleep, stays receive-only on stop
// - wake capable or off mode is left unchanged on sleep or stop entry
// - fail-safe entry forces bus register to 0000 0x01
// - in development mode the reset transceiver mode is 011
// - internal wake bit 6 enables the cyclic timer as wake source
// - internal wake bit 2 is second stop-off bit, cleared on stop to normal
// - external wake bit 7 lets all status bits, not only wakes, assert interrupt
// - external wake bit 5 selects voltage sensing, no wake events from pin
// - external wake bit 0 enables wake pin as wake source, resets to one
// - restart keeps watchdog bits 7,5,4, clears 6 and 3, timer field 100
// - restart keeps external wake bits 7,5,0 and clears the rest
// - restart keeps timer wake enable and clears the rest of internal wake
`default_nettype none
package swcwc_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] WD_ADDR = 7'h03;
  localparam logic [6:0] BUS_ADDR = 7'h04;
  localparam logic [6:0] WK0_ADDR = 7'h06;
  localparam logic [6:0] WK1_ADDR = 7'h07;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WD_PARITY_BIT = 7;
  localparam int WD_STOP_OFF_BIT = 6;
  localparam int WD_WINDOW_BIT = 5;
  localparam int WD_BUS_WAKE_BIT = 4;
  localparam int BUS_SEL_WAKE_BIT = 2;
  localparam int WK0_TIMER_BIT = 6;
  localparam int WK0_STOP_OFF_BIT = 2;
  localparam int WK1_GLOBAL_BIT = 7;
  localparam int WK1_SENSE_BIT = 5;
  localparam int WK1_PIN_EN_BIT = 0;
  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] WD_RST = 8'h14;
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic [7:0] BUS_DEV_RST = 8'h03;
  localparam logic [7:0] WK0_RST = 8'h00;
  localparam logic [7:0] WK1_RST = 8'h01;
  localparam logic [7:0] WD_WMASK = 8'hf7;
  localparam logic [7:0] BUS_WMASK = 8'h07;
  localparam logic [7:0] WK0_WMASK = 8'h44;
  localparam logic [7:0] WK1_WMASK = 8'ha1;
  // ----------------------------------------------------------------
  // restart behaviour
  // ----------------------------------------------------------------
  localparam logic [7:0] WD_RESTART_KEEP = 8'hb0;
  localparam logic [7:0] WD_RESTART_SET = 8'h04;
  localparam logic [7:0] WK0_RESTART_KEEP = 8'h40;
  localparam logic [7:0] WK1_RESTART_KEEP = 8'ha1;
  // ----------------------------------------------------------------
  // transceiver modes (low two bits)
  // ----------------------------------------------------------------
  localparam logic [1:0] CAN_OFF = 2'h0;
  localparam logic [1:0] CAN_WAKE = 2'h1;
  localparam logic [1:0] CAN_RXONLY = 2'h2;
  localparam logic [1:0] CAN_NORMAL = 2'h3;
endpackage
`default_nettype wire

// file: design/swcwc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module swcwc_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic soft_reset,
  input wire logic dev_mode,
  input wire logic sleep_entry,
  input wire logic stop_entry,
  input wire logic stop_to_normal,
  input wire logic failsafe_entry,
  input wire logic restart_entry,
  input wire logic system_error_flag,
  input wire logic wake_status_any,
  input wire logic other_status_any,
  output logic stop_wdog_off,
  output logic window_type_select,
  output logic wdog_start_after_bus_wake,
  output logic [2:0] wdog_period_field,
  output logic [1:0] can_mode,
  output logic selective_wake,
  output logic cyclic_timer_wake_enable,
  output logic pin_voltage_sense_select,
  output logic wake_pin_wake_enable,
  output logic interrupt_out_n
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] wd_r, wd_nxt;
  logic [7:0] bus_r, bus_nxt;
  logic [7:0] wk0_r, wk0_nxt;
  logic [7:0] wk1_r, wk1_nxt;
  logic [7:0] rdata_r;
  logic init_pending_r;
  logic irq_n_r;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic wd_wr = wr_en && (addr == swcwc_pkg::WD_ADDR);
  wire logic bus_wr = wr_en && (addr == swcwc_pkg::BUS_ADDR);
  wire logic wk0_wr = wr_en && (addr == swcwc_pkg::WK0_ADDR);
  wire logic wk1_wr = wr_en && (addr == swcwc_pkg::WK1_ADDR);
  // unmapped addresses read as zero
  wire logic [7:0] rd_mux =
    (addr == swcwc_pkg::WD_ADDR) ? wd_r :
    (addr == swcwc_pkg::BUS_ADDR) ? bus_r :
    (addr == swcwc_pkg::WK0_ADDR) ? wk0_r :
    (addr == swcwc_pkg::WK1_ADDR) ? wk1_r : 8'h00;
  // reload covers power-on (strap caught after release) and soft reset
  wire logic reload = init_pending_r || soft_reset;
  // plain marks cycles in which host writes and mode events may act;
  // the assertions use it too, so a change of priority shows up there
  wire logic plain = !reload && !failsafe_entry && !restart_entry;
  // sleep conversion looks at the mode a same-cycle write leaves behind,
  // so normal mode written just before sleep is still converted
  wire logic [1:0] mode_after_wr = bus_wr ? wdata[1:0] : bus_r[1:0];
  wire logic sleep_to_wake = sleep_entry &&
    (((mode_after_wr == swcwc_pkg::CAN_NORMAL) && !system_error_flag) ||
     (mode_after_wr == swcwc_pkg::CAN_RXONLY));

  // ----------------------------------------------------------------
  // next-state: reload > fail-safe > restart > host write + mode events
  // ----------------------------------------------------------------
  // hardware events win over a host write in the same cycle, so a mode
  // transition is never undone by a late write
  always_comb begin
    wd_nxt = wd_r;
    bus_nxt = bus_r;
    wk0_nxt = wk0_r;
    wk1_nxt = wk1_r;
    if (reload) begin
      wd_nxt = swcwc_pkg::WD_RST;
      bus_nxt = dev_mode ? swcwc_pkg::BUS_DEV_RST : swcwc_pkg::BUS_RST;
      wk0_nxt = swcwc_pkg::WK0_RST;
      wk1_nxt = swcwc_pkg::WK1_RST;
    end else if (failsafe_entry) begin
      // selective wake bit kept, transceiver forced to wake capable;
      // the external wake register is left alone here
      bus_nxt = {5'h00, bus_r[swcwc_pkg::BUS_SEL_WAKE_BIT], swcwc_pkg::CAN_WAKE};
    end else if (restart_entry) begin
      // the bus register keeps its mode on restart; its value there depends
      // on the cause, which is decided outside this block
      wd_nxt = (wd_r & swcwc_pkg::WD_RESTART_KEEP) | swcwc_pkg::WD_RESTART_SET;
      wk0_nxt = wk0_r & swcwc_pkg::WK0_RESTART_KEEP;
      wk1_nxt = wk1_r & swcwc_pkg::WK1_RESTART_KEEP;
    end else begin
      // parity bit is stored as written; the host keeps it even
      if (wd_wr) begin
        wd_nxt = wdata & swcwc_pkg::WD_WMASK;
      end
      if (bus_wr) begin
        bus_nxt = wdata & swcwc_pkg::BUS_WMASK;
      end
      if (wk0_wr) begin
        wk0_nxt = wdata & swcwc_pkg::WK0_WMASK;
      end
      if (wk1_wr) begin
        wk1_nxt = wdata & swcwc_pkg::WK1_WMASK;
      end
      // stop entry leaves every mode as it is; off and wake stay on sleep
      if (sleep_to_wake) begin
        bus_nxt[1:0] = swcwc_pkg::CAN_WAKE;
      end
      if (stop_to_normal) begin
        wk0_nxt[swcwc_pkg::WK0_STOP_OFF_BIT] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register flops
  // ----------------------------------------------------------------
  // the reset branch loads constants only; init_pending_r asks for one
  // reload after release so the development strap is seen as well
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_r <= swcwc_pkg::WD_RST;
      bus_r <= swcwc_pkg::BUS_RST;
      wk0_r <= swcwc_pkg::WK0_RST;
      wk1_r <= swcwc_pkg::WK1_RST;
      init_pending_r <= 1'b1;
    end else begin
      wd_r <= wd_nxt;
      bus_r <= bus_nxt;
      wk0_r <= wk0_nxt;
      wk1_r <= wk1_nxt;
      init_pending_r <= 1'b0;
    end
  end

  // read data held until the next read strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      rdata_r <= rd_mux;
    end
  end

  // interrupt request, low active; registered to avoid glitches on the pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(wake_status_any ||
                   (wk1_r[swcwc_pkg::WK1_GLOBAL_BIT] && other_status_any));
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  // fields are plain wires off the flops; downstream logic sees a new
  // setting one cycle after the write that carries it
  assign rdata = rdata_r;
  assign interrupt_out_n = irq_n_r;
  // one stray bit cannot switch the watchdog off in stop mode
  assign stop_wdog_off = wd_r[swcwc_pkg::WD_STOP_OFF_BIT] &&
                         wk0_r[swcwc_pkg::WK0_STOP_OFF_BIT];
  assign window_type_select = wd_r[swcwc_pkg::WD_WINDOW_BIT];
  assign wdog_start_after_bus_wake = wd_r[swcwc_pkg::WD_BUS_WAKE_BIT];
  assign wdog_period_field = wd_r[2:0];
  assign can_mode = bus_r[1:0];
  assign selective_wake = bus_r[swcwc_pkg::BUS_SEL_WAKE_BIT];
  assign cyclic_timer_wake_enable = wk0_r[swcwc_pkg::WK0_TIMER_BIT];
  assign pin_voltage_sense_select = wk1_r[swcwc_pkg::WK1_SENSE_BIT];
  assign wake_pin_wake_enable = wk1_r[swcwc_pkg::WK1_PIN_EN_BIT] &&
                                !wk1_r[swcwc_pkg::WK1_SENSE_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // register contents
  // ----------------------------------------------------------------
  // reserved positions are checked on the flops, so a bad mask shows
  // even when nobody reads the register back
  a_reserved_zero: assert property (
    (wd_r[3] == 1'b0) && (bus_r[7:3] == 5'h00) && ((wk0_r & 8'hbb) == 8'h00) &&
    ((wk1_r & 8'h5e) == 8'h00))
    else $error("reserved bit set");
  a_wd_write: assert property (
    plain && wd_wr |=> wd_r == ($past(wdata) & 8'hf7))
    else $error("watchdog write not stored");
  a_bus_write: assert property (
    plain && bus_wr && !sleep_entry |=> bus_r == ($past(wdata) & 8'h07))
    else $error("bus write not stored");
  a_wk0_write: assert property (
    plain && wk0_wr && !stop_to_normal |=> wk0_r == ($past(wdata) & 8'h44))
    else $error("internal wake write not stored");
  a_wk1_write: assert property (
    plain && wk1_wr |=> wk1_r == ($past(wdata) & 8'ha1))
    else $error("external wake write not stored");
  a_reload_values: assert property (
    soft_reset |=> (wd_r == 8'h14) && (wk0_r == 8'h00) && (wk1_r == 8'h01))
    else $error("soft reset values wrong");
  a_dev_reset: assert property (
    soft_reset |=> bus_r == ($past(dev_mode) ? 8'h03 : 8'h00))
    else $error("soft reset transceiver mode wrong");
  a_sel_wake_hold: assert property (
    !reload && !bus_wr |=> selective_wake == $past(selective_wake))
    else $error("selective wake bit changed by hardware");

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  a_read_bus: assert property (
    rd_en && (addr == 7'h04) |=> rdata == $past(bus_r))
    else $error("bus register read wrong");
  a_unmapped_zero: assert property (
    rd_en && !(addr inside {7'h03, 7'h04, 7'h06, 7'h07}) |=> rdata == 8'h00)
    else $error("unmapped address read not zero");

  // ----------------------------------------------------------------
  // mode transitions
  // ----------------------------------------------------------------
  // the sleep and stop checks and a_stm1_only leave out same-cycle host writes; of these cases the write checks cover only stop entry
  a_sleep_normal: assert property (
    plain && sleep_entry && !bus_wr && !system_error_flag && (bus_r[1:0] == 2'h3)
    |=> (can_mode == 2'h1) && (selective_wake == $past(selective_wake)))
    else $error("normal mode not made wake capable on sleep");
  a_sleep_system_error_flag: assert property (
    plain && sleep_entry && !bus_wr && system_error_flag && (bus_r[1:0] == 2'h3)
    |=> can_mode == 2'h3)
    else $error("normal mode converted despite system error");
  a_sleep_rxonly: assert property (
    plain && sleep_entry && !bus_wr && (bus_r[1:0] == 2'h2) |=> can_mode == 2'h1)
    else $error("receive-only not made wake capable on sleep");
  a_sleep_keep_low: assert property (
    plain && sleep_entry && !bus_wr && !bus_r[1] |=> bus_r == $past(bus_r))
    else $error("off or wake mode changed on sleep");
  a_stop_keep: assert property (
    plain && stop_entry && !sleep_entry && !bus_wr |=> bus_r == $past(bus_r))
    else $error("mode changed on stop entry");
  a_failsafe_bus: assert property (
    !reload && failsafe_entry
    |=> (bus_r[7:3] == 5'h00) && (bus_r[1:0] == 2'h1) && (bus_r[2] == $past(bus_r[2])))
    else $error("fail-safe bus value wrong");
  a_restart_wd: assert property (
    !reload && !failsafe_entry && restart_entry
    |=> (wd_r[3:0] == 4'h4) && !wd_r[6] && ((wd_r & 8'hb0) == ($past(wd_r) & 8'hb0)))
    else $error("restart watchdog value wrong");
  a_restart_wake: assert property (
    !reload && !failsafe_entry && restart_entry
    |=> (wk1_r == ($past(wk1_r) & 8'ha1)) && (wk0_r == ($past(wk0_r) & 8'h40)))
    else $error("restart wake value wrong");
  a_stm1_clear: assert property (
    plain && stop_to_normal |=> !wk0_r[2])
    else $error("second stop-off bit not cleared");
  a_stm1_only: assert property (
    plain && stop_to_normal && !wk0_wr |=> wk0_r == ($past(wk0_r) & 8'hfb))
    else $error("stop to normal touched other wake bits");

  // ----------------------------------------------------------------
  // watchdog, interrupt and wake pin outputs
  // ----------------------------------------------------------------
  a_stop_wdog_both: assert property (
    stop_wdog_off == (wd_r[6] && wk0_r[2]))
    else $error("stop watchdog off without both bits");
  a_irq_global: assert property (
    ##1 interrupt_out_n == !($past(wake_status_any) ||
      ($past(wk1_r[7]) && $past(other_status_any))))
    else $error("interrupt output mismatch");
  a_irq_wake_only: assert property (
    !wk1_r[7] && !wake_status_any |=> interrupt_out_n)
    else $error("interrupt from non-wake status");
  a_pin_sense: assert property (
    wk1_r[5] |-> !wake_pin_wake_enable)
    else $error("wake events while sensing");
  a_pin_enable: assert property (
    wk1_r[0] && !wk1_r[5] |-> wake_pin_wake_enable)
    else $error("wake pin not enabled");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_sleep_conv: cover property (plain && sleep_entry && (bus_r[1:0] == 2'h3) ##1 can_mode == 2'h1);
  c_failsafe: cover property (failsafe_entry && (bus_r[1:0] == 2'h3));
  c_restart: cover property (restart_entry && wd_r[6]);
  c_stop_off: cover property (stop_wdog_off);
  c_dev_reset: cover property (soft_reset && dev_mode);
endmodule // swcwc_regs
`default_nettype wire

// file: testbench/swcwc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// serial master stand-in: one strobe per access
// ----------------------------------------------------------------
module swcwc_host (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
  end
  // watchdog bytes get bit 7 so that all eight bits have even parity
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == swcwc_pkg::WD_ADDR) ? {^d[6:0], d[6:0]} : d;
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    addr <= ~a; // idle lines carry junk so a stale value never passes
    wdata <= ~v;
    @(negedge sys_clk); // return once the new setting has settled on the outputs
  endtask
  // read data is taken once the capturing edge has settled
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge sys_clk);
    d = rdata;
  endtask
endmodule // swcwc_host
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] WD = swcwc_pkg::WD_ADDR;
  localparam logic [6:0] BUS = swcwc_pkg::BUS_ADDR;
  localparam logic [6:0] WK0 = swcwc_pkg::WK0_ADDR;
  localparam logic [6:0] WK1 = swcwc_pkg::WK1_ADDR;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic dev_mode = 1'b0;
  logic system_error_flag = 1'b0;
  logic wake_status_any = 1'b0;
  logic other_status_any = 1'b0;
  logic [5:0] ev = 6'h00;
  logic wr_en, rd_en, stop_wdog_off, window_type_select, wdog_start_after_bus_wake;
  logic selective_wake, cyclic_timer_wake_enable, pin_voltage_sense_select;
  logic wake_pin_wake_enable, interrupt_out_n;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [2:0] wdog_period_field;
  logic [1:0] can_mode;
  int err_count = 0;
  int compares = 0;
  always #20 sys_clk = ~sys_clk;
  swcwc_host i_swcwc_host (.sys_clk, .rdata, .wr_en, .rd_en, .addr, .wdata);
  swcwc_regs i_swcwc_regs (.sys_clk, .rst_b, .wr_en, .rd_en, .addr, .wdata, .rdata,
    .soft_reset(ev[5]), .dev_mode, .sleep_entry(ev[0]), .stop_entry(ev[1]),
    .stop_to_normal(ev[2]), .failsafe_entry(ev[3]), .restart_entry(ev[4]),
    .system_error_flag, .wake_status_any, .other_status_any, .stop_wdog_off,
    .window_type_select, .wdog_start_after_bus_wake, .wdog_period_field, .can_mode,
    .selective_wake, .cyclic_timer_wake_enable, .pin_voltage_sense_select,
    .wake_pin_wake_enable, .interrupt_out_n);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    i_swcwc_host.rd(a, rv);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  // one-cycle event pulse; index picks the event line
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev <= 6'h01 << i;
    @(posedge sys_clk);
    ev <= 6'h00;
  endtask
  // interrupt output is registered, so look one edge after the status change
  task automatic intr(input logic w, input logic o, input logic e);
    @(posedge sys_clk);
    wake_status_any <= w;
    other_status_any <= o;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("interrupt_out_n", 8'(interrupt_out_n), 8'(e));
  endtask
  // hang guard: a stuck run still ends with a verdict
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rchk(WD, 8'h14);
    rchk(BUS, 8'h00);
    rchk(WK0, 8'h00);
    rchk(WK1, 8'h01);
    i_swcwc_host.wr(7'h05, 8'hff);
    rchk(7'h05, 8'h00);
    // all ones: reserved bits must read back as zero
    i_swcwc_host.wr(WD, 8'h7f);
    i_swcwc_host.wr(WK1, 8'hff);
    rchk(WD, 8'hf7);
    rchk(WK1, 8'ha1);
    chk("sense", 8'(pin_voltage_sense_select), 8'h01);
    chk("pin_wake", 8'(wake_pin_wake_enable), 8'h00);
    intr(1'b0, 1'b1, 1'b0);
    i_swcwc_host.wr(WK1, 8'h01);
    chk("pin_wake", 8'(wake_pin_wake_enable), 8'h01);
    intr(1'b0, 1'b1, 1'b1);
    intr(1'b1, 1'b0, 1'b0);
    intr(1'b0, 1'b0, 1'b1);
    // every transceiver mode through stop entry, then sleep entry
    for (int m = 0; m < 8; m++) begin
      i_swcwc_host.wr(BUS, 8'(m));
      pulse(1);
      rchk(BUS, 8'(m));
      chk("can_mode", 8'(can_mode), 8'(m & 3));
      pulse(0);
      rchk(BUS, m[1] ? 8'((m & 4) | 1) : 8'(m));
      chk("selective_wake", 8'(selective_wake), 8'(m[2]));
    end
    @(posedge sys_clk);
    system_error_flag <= 1'b1;
    i_swcwc_host.wr(BUS, 8'h03);
    pulse(0);
    rchk(BUS, 8'h03);
    @(posedge sys_clk);
    system_error_flag <= 1'b0;
    i_swcwc_host.wr(BUS, 8'h06);
    pulse(3);
    rchk(BUS, 8'h05);
    // stop-mode watchdog off needs both bits
    i_swcwc_host.wr(WD, 8'h73);
    i_swcwc_host.wr(WK0, 8'h40);
    chk("stop_off", 8'(stop_wdog_off), 8'h00);
    chk("window", 8'(window_type_select), 8'h01);
    chk("bus_wake", 8'(wdog_start_after_bus_wake), 8'h01);
    chk("period", 8'(wdog_period_field), 8'h03);
    chk("timer_wake", 8'(cyclic_timer_wake_enable), 8'h01);
    i_swcwc_host.wr(WK0, 8'hff);
    chk("stop_off", 8'(stop_wdog_off), 8'h01);
    pulse(2);
    rchk(WK0, 8'h40);
    chk("stop_off", 8'(stop_wdog_off), 8'h00);
    i_swcwc_host.wr(WK0, 8'h44);
    i_swcwc_host.wr(WK1, 8'hff);
    pulse(4);
    rchk(WD, 8'hb4);
    rchk(WK0, 8'h40);
    rchk(WK1, 8'ha1);
    rchk(BUS, 8'h05);
    // soft reset in development mode
    @(posedge sys_clk);
    dev_mode <= 1'b1;
    pulse(5);
    rchk(BUS, 8'h03);
    rchk(WD, 8'h14);
    rchk(WK1, 8'h01);
    // second reset mid-run: power-on reload also follows the development strap
    i_swcwc_host.wr(WK0, 8'h44);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rchk(BUS, 8'h03);
    rchk(WK0, 8'h00);
    chk("interrupt_out_n", 8'(interrupt_out_n), 8'h01);
    test_done();
  end
endmodule // tb
`default_nettype wire
